/* hdl/adcrs_pkg.sv */
package adcrs_pkg;

    // Bus geometry
    localparam int ADR_W   = 8;
    localparam int DAT_W   = 32;
    localparam int SEL_W   = 4;

    // Converter result geometry
    localparam int RES_W   = 10;
    localparam int CHAN_W  = 5;
    localparam int PAIRS   = 8;
    localparam int PIDX_W  = 3;
    localparam int HALF_W  = 8;

    // Register byte offsets
    localparam logic [ADR_W-1:0] MODE_OFS      = 8'h00;
    localparam logic [ADR_W-1:0] PAIR_BASE_OFS = 8'h20;
    localparam logic [ADR_W-1:0] PAIR_END_OFS  = 8'h5C;

    // Mode register field positions
    localparam int MODE_SCAN_BIT   = 0;
    localparam int MODE_REPEAT_BIT = 1;
    localparam int MODE_ITM_LO     = 2;
    localparam int MODE_ITM_HI     = 3;
    localparam int MODE_EOC_BIT    = 7;

    // Low half field positions
    localparam int LOW_OVR_BIT     = 0;
    localparam int LOW_STORED_BIT  = 1;
    localparam int LOW_DATA_LO     = 6;

    // Pair address decode: half select bit, index field start, word alignment
    localparam int         PAIR_HALF_BIT = 2;
    localparam int         PAIR_IDX_LO   = 3;
    localparam logic [1:0] WORD_ALIGN    = 2'h0;

    // Reset values
    localparam logic [1:0]       ITM_RST   = 2'h0;
    localparam logic [DAT_W-1:0] DAT_ZERO  = 32'h0000_0000;

    // Interrupt interval codes and last pair of each sequence
    localparam logic [1:0]        ITM_EACH   = 2'h0;
    localparam logic [1:0]        ITM_FOUR   = 2'h1;
    localparam logic [PIDX_W-1:0] LAST_EACH  = 3'h0;
    localparam logic [PIDX_W-1:0] LAST_FOUR  = 3'h3;
    localparam logic [PIDX_W-1:0] LAST_EIGHT = 3'h7;
    localparam logic [PIDX_W-1:0] PAIR_FIRST = 3'h0;
    localparam logic [PIDX_W-1:0] PAIR_STEP  = 3'h1;

    // One result handed over by the converter
    typedef struct packed {
        logic              valid;    // One-cycle strobe
        logic              seq_end;  // Last result of a single or scan sequence
        logic [CHAN_W-1:0] chan;     // Converted channel 0..23
        logic [RES_W-1:0]  data;     // Conversion value
    } adcrs_conv_type;

endpackage : adcrs_pkg

/* hdl/adcrs_result_mem.sv */
module adcrs_result_mem
    import adcrs_pkg::*;
(
    input  wire logic              i_clk,     // System clock
    input  wire logic              i_rst_b,   // Async reset, active low
    input  wire logic              i_wr_en,   // Store strobe
    input  wire logic [PIDX_W-1:0] i_wr_idx,  // Pair being stored
    input  wire logic [RES_W-1:0]  i_wr_data, // Result value
    input  wire logic [PIDX_W-1:0] i_rd_idx,  // Pair being read
    output logic      [RES_W-1:0]  o_rd_data  // Registered read data
);

    logic [RES_W-1:0] mem_r [PAIRS];

    // Result storage
    always_ff @(posedge i_clk) begin
        if (i_wr_en) begin
            mem_r[i_wr_idx] <= i_wr_data;
        end
    end

    // Registered read port
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rd_data <= '0;
        end else begin
            o_rd_data <= mem_r[i_rd_idx];
        end
    end

endmodule : adcrs_result_mem

/* hdl/adcrs_top.sv */
// How it works
// - Every normal result is stored into one of eight high/low result pairs 0..7.
// - Outside fixed-channel continuous mode, channel n lands in pair n modulo 8.
// - In fixed-channel continuous mode results fill consecutive pairs from pair 0.
// - With interval code 00 in that mode every result goes to pair 0.
// - With interval code 01 results fill pairs 0..3 in turn and wrap to 0.
// - With interval code 10 results fill pairs 0..7, the done event follows the eighth.
// - The end-of-conversion flag rises only once the specified pairs hold results.
// - Reading the mode register clears the end-of-conversion flag, unless a sequence ends in the same cycle.
// - The low half carries the overrun and stored flags; 0 and 1 mean valid.
// - A pair never read keeps both flags set while results keep coming.
module adcrs_top
    import adcrs_pkg::*;
(
    input  wire logic                         I_SYS_CLK,   // System clock 100 MHz
    input  wire logic                         I_RST_B,     // Async reset, active low
    input  wire logic                         I_WB_CYC,    // Wishbone cycle
    input  wire logic                         I_WB_STB,    // Wishbone strobe
    input  wire logic                         I_WB_WE,     // Wishbone write enable
    input  wire logic [adcrs_pkg::ADR_W-1:0]  I_WB_ADR,    // Wishbone byte address
    input  wire logic [adcrs_pkg::DAT_W-1:0]  I_WB_DAT,    // Wishbone write data
    input  wire logic [adcrs_pkg::SEL_W-1:0]  I_WB_SEL,    // Wishbone byte selects
    output logic      [adcrs_pkg::DAT_W-1:0]  O_WB_DAT,    // Wishbone read data
    output logic                              O_WB_ACK,    // Wishbone acknowledge
    input  wire adcrs_pkg::adcrs_conv_type    I_CONV,      // Result from converter
    output logic                              O_CONV_DONE, // Done event pulse
    output logic                              O_EOC_FLAG   // End-of-conversion flag
);
    import adcrs_pkg::*;

    logic                    scan_r;
    logic                    repeat_r;
    logic [1:0]              itm_r;
    logic                    eoc_r;
    logic [PIDX_W-1:0]       seq_r;
    logic [PAIRS-1:0]        stored_r;
    logic [PAIRS-1:0]        ovr_r;
    logic                    pend_r;
    logic                    ack_r;
    logic [DAT_W-1:0]        dat_r;
    logic                    done_r;
    logic [RES_W-1:0]        mem_rdata;
    logic                    req;
    logic                    ack_nxt;
    logic                    fixed_cont;
    logic [PIDX_W-1:0]       wr_idx;
    logic                    seq_last;
    logic                    seq_done;
    logic                    is_mode;
    logic                    is_pair;
    logic                    is_low;
    logic [PIDX_W-1:0]       rd_idx;
    logic                    mode_wr;
    logic                    mode_rd;
    logic                    low_rd;

    // Last pair of a fixed-channel continuous sequence
    function automatic logic [PIDX_W-1:0] last_pair(input logic [1:0] itm);
        unique case (itm)
            ITM_EACH: last_pair = LAST_EACH;
            ITM_FOUR: last_pair = LAST_FOUR;
            default:  last_pair = LAST_EIGHT;
        endcase
    endfunction : last_pair

    // Byte address to pair index
    function automatic logic [PIDX_W-1:0] pair_of(input logic [ADR_W-1:0] adr);
        logic [ADR_W-1:0] rel;
        rel     = adr - PAIR_BASE_OFS;
        pair_of = rel[PIDX_W+PAIR_IDX_LO-1:PAIR_IDX_LO];
    endfunction : pair_of

    // Pair index compare used by the per-pair flag updates
    function automatic logic pair_hit(input logic [PIDX_W-1:0] idx, input int k);
        pair_hit = (idx == PIDX_W'(k));
    endfunction : pair_hit

    // Bus decode
    assign req      = I_WB_CYC && I_WB_STB;
    assign ack_nxt  = req && pend_r && !ack_r;
    assign is_mode  = (I_WB_ADR == MODE_OFS);
    assign is_pair  = (I_WB_ADR >= PAIR_BASE_OFS) && (I_WB_ADR <= PAIR_END_OFS)
                      && (I_WB_ADR[PAIR_HALF_BIT-1:0] == WORD_ALIGN);
    assign is_low   = I_WB_ADR[PAIR_HALF_BIT];
    assign rd_idx   = pair_of(I_WB_ADR);
    assign mode_wr  = ack_nxt && I_WB_WE && is_mode && I_WB_SEL[0];
    assign mode_rd  = ack_nxt && !I_WB_WE && is_mode;
    assign low_rd   = ack_nxt && !I_WB_WE && is_pair && is_low;

    // Pair selection for the incoming result
    assign fixed_cont = repeat_r && !scan_r;
    assign wr_idx     = fixed_cont ? seq_r
                                   : I_CONV.chan[PIDX_W-1:0];
    // Sequence end: last pair of the interval, or the converter's end marker
    assign seq_last   = (seq_r == last_pair(itm_r));
    assign seq_done   = I_CONV.valid &&
                        (fixed_cont ? seq_last : I_CONV.seq_end);

    // Result storage
    adcrs_result_mem u_mem (
        .i_clk     (I_SYS_CLK),
        .i_rst_b   (I_RST_B),
        .i_wr_en   (I_CONV.valid),
        .i_wr_idx  (wr_idx),
        .i_wr_data (I_CONV.data),
        .i_rd_idx  (rd_idx),
        .o_rd_data (mem_rdata)
    );

    // Mode register fields
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            scan_r   <= 1'b0;
            repeat_r <= 1'b0;
            itm_r    <= ITM_RST;
        end else if (mode_wr) begin
            scan_r   <= I_WB_DAT[MODE_SCAN_BIT];
            repeat_r <= I_WB_DAT[MODE_REPEAT_BIT];
            itm_r    <= I_WB_DAT[MODE_ITM_HI:MODE_ITM_LO];
        end
    end

    // Fixed-channel sequence position, restarts on mode write
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            seq_r <= PAIR_FIRST;
        end else if (mode_wr || !fixed_cont) begin
            seq_r <= PAIR_FIRST;
        end else if (I_CONV.valid) begin
            if (seq_last) begin
                seq_r <= PAIR_FIRST;
            end else begin
                seq_r <= seq_r + PAIR_STEP;
            end
        end
    end

    // End-of-conversion flag, set wins over read clear
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            eoc_r <= 1'b0;
        end else if (seq_done) begin
            eoc_r <= 1'b1;
        end else if (mode_rd) begin
            eoc_r <= 1'b0;
        end
    end

    // Done event pulse
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            done_r <= 1'b0;
        end else begin
            done_r <= seq_done;
        end
    end

    // Per-pair stored flags; a store wins over a low-half read clear
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            stored_r <= '0;
        end else begin
            for (int k = 0; k < PAIRS; k++) begin
                if (I_CONV.valid && pair_hit(wr_idx, k)) begin
                    stored_r[k] <= 1'b1;
                end else if (low_rd && pair_hit(rd_idx, k)) begin
                    stored_r[k] <= 1'b0;
                end
            end
        end
    end

    // Per-pair overrun flags; a store onto a still-stored pair sets it
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            ovr_r <= '0;
        end else begin
            for (int k = 0; k < PAIRS; k++) begin
                if (I_CONV.valid && pair_hit(wr_idx, k)) begin
                    ovr_r[k] <= ovr_r[k] | stored_r[k];
                end else if (low_rd && pair_hit(rd_idx, k)) begin
                    ovr_r[k] <= 1'b0;
                end
            end
        end
    end

    // Two-step bus handshake: memory read, then answer
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            pend_r <= 1'b0;
            ack_r  <= 1'b0;
        end else begin
            pend_r <= req && !pend_r && !ack_r;
            ack_r  <= ack_nxt;
        end
    end

    // Read data capture; unmapped reads return zero
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            dat_r <= DAT_ZERO;
        end else if (ack_nxt) begin
            dat_r <= DAT_ZERO;
            if (is_mode) begin
                dat_r[MODE_SCAN_BIT]             <= scan_r;
                dat_r[MODE_REPEAT_BIT]           <= repeat_r;
                dat_r[MODE_ITM_HI:MODE_ITM_LO]   <= itm_r;
                dat_r[MODE_EOC_BIT]              <= eoc_r;
            end else if (is_pair && is_low) begin
                dat_r[HALF_W-1:LOW_DATA_LO]      <= mem_rdata[RES_W-HALF_W-1:0];
                dat_r[LOW_STORED_BIT]            <= stored_r[rd_idx];
                dat_r[LOW_OVR_BIT]               <= ovr_r[rd_idx];
            end else if (is_pair) begin
                dat_r[HALF_W-1:0]                <= mem_rdata[RES_W-1:RES_W-HALF_W];
            end
        end
    end

    // Outputs
    assign O_WB_ACK    = ack_r;
    assign O_WB_DAT    = dat_r;
    assign O_CONV_DONE = done_r;
    assign O_EOC_FLAG  = eoc_r;

endmodule : adcrs_top

/* testbench/adc_result_storage_bench.sv */
module adc_result_storage_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import adcrs_pkg::*;
    logic clk = 0, rst_b = 0, cyc = 0, stb = 0, we = 0, ack, done, end_of_conversion_flag;
    logic [ADR_W-1:0] adr = 8'h00;
    logic [DAT_W-1:0] wdat = 32'h0, rdat, odat;
    logic [SEL_W-1:0] sel = 4'h0;
    adcrs_conv_type conv;
    int fails = 0, checks = 0, seed = 44773;
    int ed[8], es[8], eo[8], eoc, ptr, fix, md, p, dn;
    int modes[7] = '{0, 1, 3, 2, 6, 10, 14};
    always #5 clk = ~clk;
    adcrs_top adcrs_top_i (.I_SYS_CLK(clk), .I_RST_B(rst_b), .I_WB_CYC(cyc), .I_WB_STB(stb),
        .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_DAT(wdat), .I_WB_SEL(sel), .O_WB_DAT(odat),
        .O_WB_ACK(ack), .I_CONV(conv), .O_CONV_DONE(done), .O_EOC_FLAG(end_of_conversion_flag));
    adcrs_conv_model adcrs_conv_model_i (.i_clk(clk), .o_conv(conv));
    // Comparisons
    task automatic cmp_dat(input logic [DAT_W-1:0] g, input logic [DAT_W-1:0] e);
        checks++;
        if (g !== e) begin
            fails++;
            $display("mismatch %0t data %h expected %h", $time, g, e);
        end
    endtask : cmp_dat
    task automatic cmp_bit(input logic g, input logic e);
        checks++;
        if (g !== e) begin
            fails++;
            $display("mismatch %0t flag %b expected %b", $time, g, e);
        end
    endtask : cmp_bit
    // Classic single cycle, held until ack
    task automatic bus(input logic w, input int a, input int d);
        int n;
        n = 0;
        {cyc, stb, we, adr, wdat, sel} <= {2'h3, w, ADR_W'(a), DAT_W'(d), 4'hF};
        do @(posedge clk); while (ack !== 1'b1 && ++n < 20);
        if (n >= 20) fails++;
        rdat = odat;
        {cyc, stb} <= 2'h0;
        @(posedge clk);
    endtask : bus
    // High half before low half; low read clears flags
    task automatic chk_pair(input int q);
        bus(0, PAIR_BASE_OFS + 8 * q, 0);
        cmp_dat(rdat, DAT_W'(ed[q] / 4));
        bus(0, PAIR_BASE_OFS + 8 * q + 4, 0);
        cmp_dat(rdat, DAT_W'((ed[q] % 4) * 64 + es[q] * 2 + eo[q]));
        es[q] = 0;
        eo[q] = 0;
    endtask : chk_pair
    task automatic chk_eoc();
        cmp_bit(end_of_conversion_flag, 1'(eoc));
        bus(0, MODE_OFS, 0);
        cmp_dat(rdat, DAT_W'(eoc * 128 + md));
        eoc = 0;
    endtask : chk_eoc
    task automatic wrap_up();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up
    initial begin
        #300000;
        fails++;
        wrap_up();
    end
    // Every mode, then a stream of results with reads between
    initial begin
        int ch, d;
        logic se;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 7; i++) begin
            md = modes[i];
            fix = (md % 4 == 2);
            ptr = 0;
            bus(1, MODE_OFS, md + 128);
            bus(1, PAIR_BASE_OFS, $random(seed));
            bus(0, 8'h60, 0);
            cmp_dat(rdat, DAT_ZERO);
            chk_eoc();
            for (int k = 0; k < 24; k++) begin
                ch = fix ? $unsigned($random(seed)) % 24 : k;
                d = $unsigned($random(seed)) % 1024;
                se = !fix && k % 6 == 5;
                p = fix ? ptr : ch % 8;
                eo[p] = eo[p] | es[p];
                es[p] = 1;
                ed[p] = d;
                dn = fix ? p == (md / 4 == 0 ? 0 : md / 4 == 1 ? 3 : 7) : se;
                ptr = dn ? 0 : p + 1;
                eoc = eoc | dn;
                adcrs_conv_model_i.send(CHAN_W'(ch), RES_W'(d), se);
                @(posedge clk);
                cmp_bit(done, 1'(dn));
                cmp_bit(end_of_conversion_flag, 1'(eoc));
                if (k % 3 != 1) chk_pair(p);
                if (k % 8 == 7) chk_eoc();
            end
            for (int q = 0; q < 8; q++) chk_pair(q);
        end
        wrap_up();
    end
endmodule : adc_result_storage_bench

/* testbench/adcrs_conv_model.sv */
module adcrs_conv_model
    import adcrs_pkg::*;
(
    input  wire logic             i_clk,  // System clock
    output adcrs_pkg::adcrs_conv_type o_conv  // Result to the block
);
    timeunit 1ns;
    timeprecision 1ps;
    initial o_conv = '0;
    // One strobe per call; fields turn to garbage once released
    task automatic send(input logic [CHAN_W-1:0] ch, input logic [RES_W-1:0] d, input logic se);
        o_conv <= {1'b1, se, ch, d};
        @(posedge i_clk);
        o_conv <= {1'b0, ~se, ~ch, ~d};
    endtask : send
endmodule : adcrs_conv_model

/* testbench/adcrs_top_chk.sv */
module adcrs_top_chk
    import adcrs_pkg::*;
(
    input wire logic                           I_SYS_CLK,   // Clock
    input wire logic                           I_RST_B,     // Reset, active low
    input wire logic                           I_WB_CYC,    // Cycle
    input wire logic                           I_WB_STB,    // Strobe
    input wire logic                           I_WB_WE,     // Write
    input wire logic [adcrs_pkg::ADR_W-1:0]    I_WB_ADR,    // Address
    input wire logic [adcrs_pkg::DAT_W-1:0]    I_WB_DAT,    // Write data
    input wire logic [adcrs_pkg::SEL_W-1:0]    I_WB_SEL,    // Selects
    input wire logic [adcrs_pkg::DAT_W-1:0]    O_WB_DAT,    // Read data
    input wire logic                           O_WB_ACK,    // Acknowledge
    input wire adcrs_pkg::adcrs_conv_type      I_CONV,      // Converter result
    input wire logic                           O_CONV_DONE, // Done pulse
    input wire logic                           O_EOC_FLAG   // End of conversion
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RST_B);
    // Mode register read being answered
    logic mode_rd;
    assign mode_rd = O_WB_ACK && !I_WB_WE && I_WB_ADR == MODE_OFS;
    a_ack_delay: assert property ($rose(I_WB_STB) |-> ##1 !O_WB_ACK ##1 O_WB_ACK)
        else $error("ack not two cycles after request");
    a_ack_single: assert property (O_WB_ACK |=> !O_WB_ACK) else $error("ack too long");
    a_ack_in_cycle: assert property (O_WB_ACK |-> I_WB_CYC && I_WB_STB) else $error("stray ack");
    a_done_eoc: assert property (O_CONV_DONE |-> O_EOC_FLAG) else $error("done without eoc");
    a_done_cause: assert property (O_CONV_DONE |-> $past(I_CONV.valid))
        else $error("done without result");
    a_eoc_rise: assert property ($rose(O_EOC_FLAG) |-> $past(I_CONV.valid))
        else $error("eoc rose without result");
    a_eoc_fall: assert property ($fell(O_EOC_FLAG) |-> mode_rd) else $error("eoc lost");
    a_eoc_clear: assert property (mode_rd && !$past(I_CONV.valid) |-> !O_EOC_FLAG)
        else $error("eoc not cleared by read");
    a_mode_bit: assert property (mode_rd |-> O_WB_DAT[MODE_EOC_BIT] == $past(O_EOC_FLAG))
        else $error("eoc bit wrong in read");
    a_unmapped_zero: assert property (O_WB_ACK && !I_WB_WE && I_WB_ADR >= 8'h60 |->
        O_WB_DAT == DAT_ZERO) else $error("unmapped read not zero");
endmodule : adcrs_top_chk

bind adcrs_top adcrs_top_chk adcrs_top_chk_i (.I_SYS_CLK(I_SYS_CLK), .I_RST_B(I_RST_B),
    .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR),
    .I_WB_DAT(I_WB_DAT), .I_WB_SEL(I_WB_SEL), .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK),
    .I_CONV(I_CONV), .O_CONV_DONE(O_CONV_DONE), .O_EOC_FLAG(O_EOC_FLAG));
